// >>> logic/lcm_pkg.sv
/*
  Shared types and constants of the look-up logic cell: mode codes,
  configuration and group-control carriers, state record and reset values.
  Assumes the importing modules run on one clock with one asynchronous reset.
*/
package lcm_pkg;

  // ----------------------------------------------------------------
  // Cell group geometry
  // ----------------------------------------------------------------
  localparam int unsigned LCM_GROUP_CELLS = 10;
  localparam int unsigned LCM_FIRST_POS   = 1;
  localparam int unsigned LCM_SECOND_POS  = 2;
  localparam int unsigned LCM_LUT_INPUTS  = 4;
  localparam int unsigned LCM_HALF_INPUTS = 3;
  localparam int unsigned LCM_MASK_W      = 16;
  localparam int unsigned LCM_HALF_W      = 8;
  localparam int unsigned LCM_ENA_COUNT   = 2;

  // ----------------------------------------------------------------
  // Emulation cost
  // ----------------------------------------------------------------
  localparam logic [1:0] LCM_EXTRA_CELLS_EMUL = 2'h3;
  localparam logic [1:0] LCM_EXTRA_CELLS_NONE = 2'h0;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LCM_MODE_NORMAL  = 3'h1,
    LCM_MODE_ARITH   = 3'h2,
    LCM_MODE_COUNTER = 3'h4
  } lcm_mode_t;

  // ----------------------------------------------------------------
  // Static configuration of one cell
  // ----------------------------------------------------------------
  typedef struct packed {
    lcm_mode_t        mode;
    logic [15:0]      lut_mask;
    logic             use_carry_in;
    logic             cascade_en;
    logic             cascade_or;
    logic             pack_en;
    logic             clk_sel;
    logic             fb_sel;
    logic             preset_en;
    logic             emul_en;
    logic             dev_reset_en;
  } lcm_cfg_t;

  // ----------------------------------------------------------------
  // Group-wide register controls, all active high
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] clk_ena;
    logic       async_clr;
    logic       async_pre;
    logic       async_load;
    logic       sync_clr;
    logic       sync_load;
  } lcm_grp_t;

  // ----------------------------------------------------------------
  // Cell state record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] rst_sync;
    logic       rst_filt;
    logic       powered;
    logic       reg_val;
    logic       comb_val;
    logic       carry_val;
    logic       casc_val;
    logic       unknown;
    logic       mode_err;
    logic [1:0] extra_cells;
  } lcm_state_t;

  localparam logic [2:0] LCM_RST_SYNC_INIT = 3'h7;
  localparam lcm_state_t LCM_STATE_RST = '{
    rst_sync    : LCM_RST_SYNC_INIT,
    rst_filt    : 1'b1,
    powered     : 1'b0,
    reg_val     : 1'b0,
    comb_val    : 1'b0,
    carry_val   : 1'b0,
    casc_val    : 1'b0,
    unknown     : 1'b0,
    mode_err    : 1'b0,
    extra_cells : 2'h0
  };

endpackage : lcm_pkg

// >>> logic/lcm_lut.sv
/*
  Generic look-up function: one output bit chosen from a truth-table mask.
  Assumes the mask is static configuration; purely combinational.
*/
`timescale 1ns/100ps

module lcm_lut
  import lcm_pkg::*;
#(
  parameter int unsigned N = 4
)
(
  input  wire logic [(2**N)-1:0] mask_i,
  input  wire logic [N-1:0]      sel_i,
  output logic                   out_o
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if ((N < 1) || (N > 6))
  begin : g_bad_n
    $error("lcm_lut: N must lie in 1..6");
  end

  // ----------------------------------------------------------------
  // Table lookup
  // ----------------------------------------------------------------
  always_comb
  begin
    out_o = mask_i[sel_i];
  end

endmodule : lcm_lut

// >>> logic/lcm_cell.sv
/*
  One programmable logic cell: four-input look-up function, carry and
  cascade links, and one configurable register in normal, arithmetic or
  counter mode, with group-wide controls and a filtered device-wide reset.
  Assumes configuration and group controls come from logic on core_clk_i;
  only the device-wide reset comes from a pin.
*/
// Functional notes
// - Exactly one of normal, arithmetic or counter mode is active per cell.
// - Seven inputs: four data, register feedback, carry-in and cascade-in.
// - Register controls come from shared group-wide signals in every mode.
// - Group offers two clock enables; each cell register selects one.
// - Normal mode four-input lookup; carry-in or input c feeds one input.
// - Normal mode lookup output combines with cascade-in into cascade-out.
// - Normal mode packs unrelated register data, not when carry-in used.
// - Arithmetic mode: two three-input lookups give result and carry-out.
// - Arithmetic mode allows cascade and both registered and unregistered outputs.
// - Counter mode: enable, direction, sync clear and load; a, b steer.
// - Sync clear and load are group-wide and hit every register.
// - Counter uses count and carry functions, load mux, clear AND gate.
// - In counter mode sync clear or load override the cascade value.
// - Sync clear beats sync load when both asserted.
// - Inputs a and b steer counter or feedback except in second cell.
// - Only the first cell of a group has a feedback selector.
// - Native async clear; preset built by inversion around the clear.
// - Emulating preset plus clear or async load costs three cells.
// - Emulated preset-and-load registers are undefined after power-up, reset.
// - Enabled device-wide reset resets registers above every other control.
// - Preset registers show one while the device-wide reset is asserted.
// - Two clocks each tied to own enable; clock one uses enable one.
`timescale 1ns/100ps

module lcm_cell
  import lcm_pkg::*;
#(
  parameter int unsigned CELL_POS = 1
)
(
  input  wire logic      core_clk_i,
  input  wire logic      reset_i,
  input  wire lcm_cfg_t  cfg_i,
  input  wire lcm_grp_t  grp_i,
  input  wire logic      cell_input_a_i,
  input  wire logic      cell_input_b_i,
  input  wire logic      cell_input_c_i,
  input  wire logic      cell_input_d_i,
  input  wire logic      carry_in_i,
  input  wire logic      cascade_in_i,
  input  wire logic      device_wide_reset_low_i,
  output logic           comb_out_o,
  output logic           reg_out_o,
  output logic           carry_out_o,
  output logic           cascade_out_o,
  output logic           state_unknown_o,
  output logic           mode_err_o,
  output logic [1:0]     extra_cells_o
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if ((CELL_POS < 1) || (CELL_POS > LCM_GROUP_CELLS))
  begin : g_bad_pos
    $error("lcm_cell: CELL_POS must lie within the cell group");
  end

  // ----------------------------------------------------------------
  // Package geometry check
  // ----------------------------------------------------------------
  // The arithmetic split halves the full mask, one half per lookup
  if ((LCM_MASK_W != (32'h1 << LCM_LUT_INPUTS)) || (LCM_HALF_W != (32'h1 << LCM_HALF_INPUTS)))
  begin : g_bad_mask
    $error("lcm_cell: lookup mask widths do not fit the input counts");
  end

  if ((LCM_HALF_W + LCM_HALF_W) != LCM_MASK_W)
  begin : g_bad_split
    $error("lcm_cell: two half tables must fill the full mask");
  end

  // clk_sel is one bit, so only two enables can be told apart
  if (LCM_ENA_COUNT != 32'h2)
  begin : g_bad_ena
    $error("lcm_cell: the group must offer exactly two clock enables");
  end

  // Role decode compares against these positions, so they must differ
  if ((LCM_FIRST_POS == LCM_SECOND_POS) || (LCM_SECOND_POS > LCM_GROUP_CELLS))
  begin : g_bad_roles
    $error("lcm_cell: first and second cell positions are inconsistent");
  end

  localparam logic IS_FIRST  = (CELL_POS == LCM_FIRST_POS);
  localparam logic IS_SECOND = (CELL_POS == LCM_SECOND_POS);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  lcm_state_t st_q;
  lcm_state_t st_d;

  logic                  lut_a;
  logic                  lut_c;
  logic [LCM_LUT_INPUTS-1:0]  sel4;
  logic [LCM_HALF_INPUTS-1:0] sel3;
  logic                  lut4_out;
  logic                  sum_out;
  logic                  cry_out;

  // ----------------------------------------------------------------
  // Lookup input steering
  // ----------------------------------------------------------------
  // Feedback replaces input a only where the selector physically exists
  assign lut_a = (IS_FIRST && cfg_i.fb_sel) ? st_q.reg_val : cell_input_a_i;
  assign lut_c = cfg_i.use_carry_in ? carry_in_i : cell_input_c_i;
  assign sel4  = {cell_input_d_i, lut_c, cell_input_b_i, lut_a};
  assign sel3  = {carry_in_i, cell_input_b_i, lut_a};

  // ----------------------------------------------------------------
  // Lookup functions
  // ----------------------------------------------------------------
  lcm_lut #(
    .N      (LCM_LUT_INPUTS)
  ) u_lut4 (
    .mask_i (cfg_i.lut_mask),
    .sel_i  (sel4),
    .out_o  (lut4_out)
  );

  // Upper half of the mask computes the result, lower half the carry
  lcm_lut #(
    .N      (LCM_HALF_INPUTS)
  ) u_sum (
    .mask_i (cfg_i.lut_mask[LCM_MASK_W-1:LCM_HALF_W]),
    .sel_i  (sel3),
    .out_o  (sum_out)
  );

  lcm_lut #(
    .N      (LCM_HALF_INPUTS)
  ) u_cry (
    .mask_i (cfg_i.lut_mask[LCM_HALF_W-1:0]),
    .sel_i  (sel3),
    .out_o  (cry_out)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic fn_val;
    logic casc_val;
    logic carry_val;
    logic reg_fn;
    logic cnt_en;
    logic cnt_up;
    logic toggle;
    logic count;
    logic ld_mux;
    logic sync_val;
    logic clk_ena;
    logic dev_rst;
    logic pre_ok;
    logic aload_ok;

    st_d      = st_q;
    fn_val    = 1'b0;
    casc_val  = 1'b0;
    carry_val = 1'b0;
    reg_fn    = st_q.reg_val;
    cnt_en    = 1'b0;
    cnt_up    = 1'b0;
    toggle    = 1'b0;
    count     = 1'b0;
    ld_mux    = 1'b0;
    sync_val  = 1'b0;
    clk_ena   = 1'b0;
    dev_rst   = 1'b0;
    pre_ok    = 1'b0;
    aload_ok  = 1'b0;

    // Pin reset filter: a level counts once the second and third stage agree
    st_d.rst_sync = {st_q.rst_sync[1:0], device_wide_reset_low_i};
    if (st_q.rst_sync[2] == st_q.rst_sync[1])
    begin
      st_d.rst_filt = st_q.rst_sync[2];
    end
    st_d.powered = 1'b1;

    // Cell function per mode
    st_d.mode_err = 1'b0;
    case (cfg_i.mode)
      LCM_MODE_NORMAL:
      begin
        fn_val = lut4_out;
        if (cfg_i.cascade_en)
        begin
          // OR link is the De Morgan form of the AND chain
          casc_val = cfg_i.cascade_or ? (fn_val | cascade_in_i) : (fn_val & cascade_in_i);
        end
        else
        begin
          casc_val = fn_val;
        end
        carry_val = 1'b0;
        // Packing sends input d to the register, and carry-in use forbids it
        if (cfg_i.pack_en && !cfg_i.use_carry_in)
        begin
          reg_fn = cell_input_d_i;
        end
        else
        begin
          reg_fn = casc_val;
        end
      end
      LCM_MODE_ARITH:
      begin
        fn_val = sum_out;
        if (cfg_i.cascade_en)
        begin
          casc_val = cfg_i.cascade_or ? (fn_val | cascade_in_i) : (fn_val & cascade_in_i);
        end
        else
        begin
          casc_val = fn_val;
        end
        carry_val = cry_out;
        reg_fn    = casc_val;
      end
      LCM_MODE_COUNTER:
      begin
        // Second cell has no free a and b for counter steering
        cnt_en    = IS_SECOND ? 1'b1 : cell_input_a_i;
        cnt_up    = IS_SECOND ? 1'b1 : cell_input_b_i;
        toggle    = cnt_en & carry_in_i;
        count     = st_q.reg_val ^ toggle;
        carry_val = toggle & (cnt_up ? st_q.reg_val : ~st_q.reg_val);
        fn_val    = count;
        if (cfg_i.cascade_en)
        begin
          casc_val = cfg_i.cascade_or ? (fn_val | cascade_in_i) : (fn_val & cascade_in_i);
        end
        else
        begin
          casc_val = fn_val;
        end
        reg_fn = casc_val;
      end
      default:
      begin
        // Not one-hot: outputs quiet, register holds unless a group control or device reset acts
        st_d.mode_err = 1'b1;
        fn_val        = 1'b0;
        casc_val      = 1'b0;
        carry_val     = 1'b0;
        reg_fn        = st_q.reg_val;
      end
    endcase

    st_d.comb_val  = casc_val;
    st_d.casc_val  = casc_val;
    st_d.carry_val = carry_val;

    // Sync load mux then clear gate, so clear wins and cascade loses
    ld_mux   = grp_i.sync_load ? cell_input_c_i : reg_fn;
    sync_val = ld_mux & ~grp_i.sync_clr;

    // Clock select fixes the enable too, so the pair never splits
    clk_ena = grp_i.clk_ena[cfg_i.clk_sel];

    // Async controls; preset needs the inversion, async load the emulation
    dev_rst  = cfg_i.dev_reset_en & ~st_q.rst_filt;
    pre_ok   = cfg_i.preset_en | cfg_i.emul_en;
    aload_ok = cfg_i.emul_en;

    if (dev_rst)
    begin
      // Inverted storage makes a preset register read one here
      st_d.reg_val = cfg_i.preset_en;
      st_d.unknown = cfg_i.emul_en;
    end
    else if (grp_i.async_clr)
    begin
      st_d.reg_val = 1'b0;
      st_d.unknown = 1'b0;
    end
    else if (grp_i.async_pre && pre_ok)
    begin
      st_d.reg_val = 1'b1;
      st_d.unknown = 1'b0;
    end
    else if (grp_i.async_load && aload_ok)
    begin
      st_d.reg_val = cell_input_c_i;
      st_d.unknown = 1'b0;
    end
    else if (clk_ena)
    begin
      st_d.reg_val = sync_val;
      if (grp_i.sync_clr || grp_i.sync_load)
      begin
        st_d.unknown = 1'b0;
      end
    end

    // First cycle after power-up: emulated register has no defined value
    if (!st_q.powered && cfg_i.emul_en)
    begin
      st_d.unknown = 1'b1;
    end
    else if (!cfg_i.emul_en)
    begin
      st_d.unknown = 1'b0;
    end

    st_d.extra_cells = cfg_i.emul_en ? LCM_EXTRA_CELLS_EMUL : LCM_EXTRA_CELLS_NONE;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_q <= LCM_STATE_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Chain outputs are registered, so each cell adds one cycle of latency
  assign comb_out_o      = st_q.comb_val;
  assign reg_out_o       = st_q.reg_val;
  assign carry_out_o     = st_q.carry_val;
  assign cascade_out_o   = st_q.casc_val;
  assign state_unknown_o = st_q.unknown;
  assign mode_err_o      = st_q.mode_err;
  assign extra_cells_o   = st_q.extra_cells;

endmodule : lcm_cell

// >>> tb/lcm_cell_chk.sv
/*
  Port-level checker for lcm_cell, bound into every instance.
  Assumes one clock and the active-high asynchronous reset_i.
*/
`timescale 1ns/100ps

module lcm_cell_chk
  import lcm_pkg::*;
#(
  parameter int unsigned CELL_POS = 1
)
(
  input wire logic       core_clk_i,
  input wire logic       reset_i,
  input wire lcm_cfg_t   cfg_i,
  input wire lcm_grp_t   grp_i,
  input wire logic       cell_input_a_i,
  input wire logic       cell_input_c_i,
  input wire logic       carry_in_i,
  input wire logic       cascade_in_i,
  input wire logic       device_wide_reset_low_i,
  input wire logic       comb_out_o,
  input wire logic       reg_out_o,
  input wire logic       carry_out_o,
  input wire logic       cascade_out_o,
  input wire logic       state_unknown_o,
  input wire logic       mode_err_o,
  input wire logic [1:0] extra_cells_o
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic live_q;
  logic valid_w, ok_w, asy_w, ena_w, quiet_w;

  assign valid_w = cfg_i.mode inside {LCM_MODE_NORMAL, LCM_MODE_ARITH, LCM_MODE_COUNTER};
  assign ok_w    = valid_w & !cfg_i.dev_reset_en;
  assign ena_w   = grp_i.clk_ena[cfg_i.clk_sel];
  assign asy_w   = grp_i.async_clr | (grp_i.async_pre & (cfg_i.preset_en | cfg_i.emul_en))
                 | (grp_i.async_load & cfg_i.emul_en);
  assign quiet_w = ok_w & !asy_w & ena_w;

  // Outputs after an edge taken in reset carry no input history
  always_ff @(posedge core_clk_i or posedge reset_i)
    if (reset_i)
      live_q <= 1'b0;
    else
      live_q <= 1'b1;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  sequence dev_held_s;
    (cfg_i.dev_reset_en && !device_wide_reset_low_i) [*5];
  endsequence
  sequence clr_req_s;
    quiet_w && grp_i.sync_clr;
  endsequence
  sequence load_req_s;
    quiet_w && !grp_i.sync_clr && grp_i.sync_load;
  endsequence

  chk_sync_clr_wins: assert property (clr_req_s ##1 live_q |-> !reg_out_o)
    else $error("sync clear did not clear");
  chk_sync_load_c: assert property (load_req_s ##1 live_q |-> reg_out_o == $past(cell_input_c_i))
    else $error("sync load value wrong");
  chk_hold_no_ena: assert property ((ok_w && !asy_w && !ena_w) ##1 live_q |-> $stable(reg_out_o))
    else $error("register moved without enable");
  chk_async_clr_zero: assert property ((grp_i.async_clr && !cfg_i.dev_reset_en) ##1 live_q |-> !reg_out_o)
    else $error("async clear ignored");
  chk_cascade_copy: assert property ((valid_w && cfg_i.cascade_en && (cfg_i.cascade_or == cascade_in_i)) ##1 live_q
      |-> cascade_out_o == $past(cascade_in_i) && comb_out_o == cascade_out_o)
    else $error("cascade link not applied");
  chk_normal_no_carry: assert property ((cfg_i.mode == LCM_MODE_NORMAL) ##1 live_q |-> !carry_out_o)
    else $error("carry out in normal mode");
  chk_bad_mode_flag: assert property (!valid_w ##1 live_q |-> mode_err_o && !comb_out_o && !carry_out_o)
    else $error("invalid mode not flagged");
  chk_extra_cell_cost: assert property (live_q |->
      extra_cells_o == ($past(cfg_i.emul_en) ? LCM_EXTRA_CELLS_EMUL : LCM_EXTRA_CELLS_NONE))
    else $error("extra cell count wrong");
  chk_dev_reset_hold: assert property (dev_held_s |=>
      reg_out_o == cfg_i.preset_en && state_unknown_o == cfg_i.emul_en)
    else $error("device reset not applied");
  chk_count_toggle: assert property ((quiet_w && cfg_i.mode == LCM_MODE_COUNTER && !grp_i.sync_clr
      && !grp_i.sync_load && !cfg_i.cascade_en && cell_input_a_i && carry_in_i) ##1 live_q
      |-> reg_out_o != $past(reg_out_o))
    else $error("counter did not step");
endmodule : lcm_cell_chk

bind lcm_cell lcm_cell_chk #(.CELL_POS(CELL_POS)) u_lcm_cell_chk (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .cfg_i(cfg_i), .grp_i(grp_i),
  .cell_input_a_i(cell_input_a_i), .cell_input_c_i(cell_input_c_i), .carry_in_i(carry_in_i),
  .cascade_in_i(cascade_in_i),
  .device_wide_reset_low_i(device_wide_reset_low_i), .comb_out_o(comb_out_o), .reg_out_o(reg_out_o),
  .carry_out_o(carry_out_o), .cascade_out_o(cascade_out_o), .state_unknown_o(state_unknown_o),
  .mode_err_o(mode_err_o), .extra_cells_o(extra_cells_o)
);

// >>> tb/lcm_chain_src.sv
/*
  Lower-order neighbour cell: drives carry-in and cascade-in of the cell.
  Assumes the same clock and reset as the cell under test.
*/
`timescale 1ns/100ps

module lcm_chain_src
(
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  output logic      carry_o,
  output logic      cascade_o
);
  logic [3:0] cnt_q;

  // Outputs move only after a rising edge, as a registered neighbour does
  always_ff @(posedge core_clk_i or posedge reset_i)
    if (reset_i)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_q + 4'h5;

  assign carry_o   = cnt_q[0] | cnt_q[2];
  assign cascade_o = cnt_q[1] ^ cnt_q[3];
endmodule : lcm_chain_src

// >>> tb/lcm_cell_test.sv
/*
  Self-checking bench for lcm_cell fed by a neighbour-cell model.
  Assumes lcm_pkg, lcm_cell, the checker and lcm_chain_src are compiled first.
*/
`timescale 1ns/100ps

module lcm_cell_test;
  import lcm_pkg::*;

  typedef struct packed {
    logic f;
    logic r;
    logic k;
    logic u;
    logic m;
  } lcm_exp_t;

  logic       core_clk_i = 1'b0;
  logic       reset_i    = 1'b1;
  lcm_cfg_t   cfg        = '0;
  lcm_cfg_t   pc;
  lcm_grp_t   grp        = '0;
  logic [3:0] din        = 4'h0;
  logic       dwr_n      = 1'b1;
  logic       mr         = 1'b0;
  logic       cin, casc, comb, rego, cout, unk, merr, cso;
  logic [1:0] xc;
  lcm_exp_t   q[$];
  lcm_exp_t   exp_e;
  int         error_cnt = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  lcm_mode_t  modes[4] = '{LCM_MODE_NORMAL, LCM_MODE_ARITH, LCM_MODE_COUNTER, lcm_mode_t'(3'h6)};

  always #4 core_clk_i = ~core_clk_i;

  lcm_chain_src u_lcm_chain_src (.core_clk_i(core_clk_i), .reset_i(reset_i), .carry_o(cin), .cascade_o(casc));

  lcm_cell u_lcm_cell (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .cfg_i(cfg), .grp_i(grp),
    .cell_input_a_i(din[0]), .cell_input_b_i(din[1]), .cell_input_c_i(din[2]), .cell_input_d_i(din[3]),
    .carry_in_i(cin), .cascade_in_i(casc), .device_wide_reset_low_i(dwr_n),
    .comb_out_o(comb), .reg_out_o(rego), .carry_out_o(cout), .cascade_out_o(cso),
    .state_unknown_o(unk), .mode_err_o(merr), .extra_cells_o(xc)
  );

  // ----------------------------------------------------------------
  // Compare and close
  // ----------------------------------------------------------------
  task automatic cmp(input logic [4:0] got, input logic [4:0] want, input string what);
    samples_checked++;
    if (got !== want)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, want);
    end
  endtask : cmp

  task automatic end_sim();
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // One random cycle and its expected outputs
  // ----------------------------------------------------------------
  task automatic step(input lcm_cfg_t nc);
    logic ae, f, k, ena, nr, bad;
    @(negedge core_clk_i);
    cfg = nc;
    din = 4'($urandom);
    grp = lcm_grp_t'(7'($urandom & $urandom & $urandom));
    grp.clk_ena = 2'($urandom);
    bad = !(cfg.mode inside {LCM_MODE_NORMAL, LCM_MODE_ARITH, LCM_MODE_COUNTER});
    if (bad)
      grp = '0;
    ae = cfg.fb_sel ? mr : din[0];
    ena = grp.clk_ena[cfg.clk_sel];
    f = 1'b0;
    k = 1'b0;
    case (cfg.mode)
      LCM_MODE_NORMAL: f = cfg.lut_mask[{din[3], cfg.use_carry_in ? cin : din[2], din[1], ae}];
      LCM_MODE_ARITH:
      begin
        f = cfg.lut_mask[{1'b1, cin, din[1], ae}];
        k = cfg.lut_mask[{1'b0, cin, din[1], ae}];
      end
      LCM_MODE_COUNTER:
      begin
        f = mr ^ (din[0] & cin);
        k = din[0] & cin & (din[1] ? mr : ~mr);
      end
      default: ;
    endcase
    if (cfg.cascade_en && !bad)
      f = cfg.cascade_or ? (f | casc) : (f & casc);
    nr = mr;
    if (grp.async_clr)
      nr = 1'b0;
    else if (grp.async_pre && (cfg.preset_en || cfg.emul_en))
      nr = 1'b1;
    else if (grp.async_load && cfg.emul_en)
      nr = din[2];
    else if (ena && grp.sync_clr)
      nr = 1'b0;
    else if (ena && grp.sync_load)
      nr = din[2];
    else if (ena && !bad)
      nr = (cfg.mode == LCM_MODE_NORMAL && cfg.pack_en && !cfg.use_carry_in) ? din[3] : f;
    q.push_back(lcm_exp_t'{f, nr, k, 1'b0, bad});
    mr = nr;
  endtask : step

  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      end_sim();
    end
    else if (q.size() > 0)
    begin
      exp_e = q.pop_front();
      #1;
      cmp({comb, rego, cout, unk, merr}, exp_e, "cell outputs");
      cmp({4'h0, cso}, {4'h0, exp_e.f}, "cascade out");
    end
  end

  initial
  begin
    void'($urandom(32'h04acfea5));
    cfg.mode = LCM_MODE_NORMAL;
    repeat (4) @(negedge core_clk_i);
    reset_i = 1'b0;
    for (int p = 0; p < 16; p++)
    begin
      pc = lcm_cfg_t'(28'($urandom));
      pc.mode = modes[p % 4];
      pc.dev_reset_en = 1'b0;
      if (pc.mode == LCM_MODE_COUNTER)
        pc.fb_sel = 1'b0;
      repeat (40) step(pc);
      $display("test %0d mode %h done", p, pc.mode);
    end
    @(negedge core_clk_i);
    cfg.dev_reset_en = 1'b1;
    cfg.preset_en = 1'b1;
    cfg.emul_en = 1'b1;
    grp = '0;
    grp.async_clr = 1'b1;
    grp.clk_ena = 2'h3;
    grp.sync_load = 1'b1;
    dwr_n = 1'b0;
    repeat (6) @(negedge core_clk_i);
    cmp({3'h0, rego, unk}, 5'h03, "preset under device reset");
    cmp({3'h0, xc}, 5'h03, "emulation cost");
    dwr_n = 1'b1;
    repeat (6) @(negedge core_clk_i);
    cmp({3'h0, rego, unk}, 5'h00, "clear after device reset");
    $display("test device reset done");
    reset_i = 1'b1;
    grp = '0;
    @(negedge core_clk_i);
    reset_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    cmp({4'h0, unk}, 5'h01, "undefined at power-up");
    $display("test power-up done");
    end_sim();
  end
endmodule : lcm_cell_test
